// ---- rtl/pin_sync.sv ----
// Three-stage pin synchroniser that accepts a level once stages agree
`timescale 1ns/1ns
module pin_sync
    import spi_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Pin levels in and filtered levels out
    input  wire logic [`NPINS-1:0] d,
    output logic      [`NPINS-1:0] q
);

    sync_t sync_reg;
    sync_t sync_next;

    // Shift chain; stable follows only when stages two and three agree
    always_comb
    begin
        sync_next        = sync_reg;
        sync_next.s1     = d;
        sync_next.s2     = sync_reg.s1;
        sync_next.s3     = sync_reg.s2;
        sync_next.stable = (~(sync_reg.s2 ^ sync_reg.s3) & sync_reg.s3)
                         | ((sync_reg.s2 ^ sync_reg.s3) & sync_reg.stable);
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            sync_reg <= '{default: `SYNC_RESET};
        else
            sync_reg <= sync_next;
    end

    assign q = sync_reg.stable;

endmodule : pin_sync

// ---- rtl/spi_cfg.svh ----
// Register map, field positions, reset values and counts of the serial port
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_DATA 8'h08
`define OFS_PINS 8'h0C
// control_register_a fields
`define CA_RXIE 7
`define CA_MSTR 5
`define CA_CPOL 4
`define CA_CLOCK_PHASE 3
`define CA_WOM 2
`define CA_SPE 1
`define CA_TXIE 0
`define CA_RESET 8'h28
`define CA_MASK 8'hBF
// status_control_register fields
`define SC_RXF 7
`define SC_ERROR_IRQ_ENABLE 6
`define SC_OVR 5
`define SC_MODE_FAULT_FLAG 4
`define SC_TXE 3
`define SC_MODE_FAULT_ENABLE 2
`define SC_RATE_HI 1
`define SC_RATE_LO 0
// Pin indices of the shared port
`define PIN_MISO 0
`define PIN_MOSI 1
`define PIN_SCK 2
`define PIN_SS 3
`define NPINS 4
// Synchroniser reset level (pins idle high)
`define SYNC_RESET 4'hF
// Half serial clock period in bus clocks, minus one
`define HALF_BD0 7'h01
`define HALF_BD1 7'h07
`define HALF_BD2 7'h1F
`define HALF_BD3 7'h7F
// Last of the sixteen serial clock edges of a byte
`define EDGES_LAST 4'hF
`endif

// ---- rtl/spi_enable_reset_pin_control.sv ----
// Serial port core: registers, transfer engine, resets and pin ownership
`timescale 1ns/1ns
module spi_enable_reset_pin_control
    import spi_pkg::*;
(
    // Clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // System state
    input  wire logic              WAIT_MODE,
    input  wire logic              STOP_MODE,
    input  wire logic              BREAK_ACTIVE,
    input  wire logic              BREAK_CLEAR_EN,
    // Shared port direction and data
    input  wire logic [`NPINS-1:0] PORT_DDR,
    input  wire logic [`NPINS-1:0] PORT_DOUT,
    output logic      [`NPINS-1:0] PORT_DIN,
    // Pins
    input  wire logic [`NPINS-1:0] PIN_I,
    output logic      [`NPINS-1:0] PIN_O,
    output logic      [`NPINS-1:0] PIN_OE,
    // Requests
    output logic                   TX_IRQ,
    output logic                   RX_ERR_IRQ,
    output logic                   WAKE
);

    // Constant reset image of the core
    localparam core_t CORE_RST = '{
        ctrl:    `CA_RESET,
        txe:     1'b1,
        ss_prev: 1'b1,
        sck_prev: 1'b1,
        st:      ST_IDLE,
        default: '0
    };

    core_t             core_reg;
    core_t             core_next;
    logic [`NPINS-1:0] pin_s;
    logic [`NPINS-1:0] spi_o;
    logic [`NPINS-1:0] spi_oe;
    logic [`NPINS-1:0] own;
    logic              serial_port_enable;
    logic              mstr;
    logic              cpol;
    logic              clock_phase;
    logic              wom;
    logic              ss_low;
    logic              ss_rise;
    logic              ss_fall;
    logic              sck_in;
    logic              sck_edge;
    logic              in_bit;
    logic              protect;
    logic              access;
    logic              wr;
    logic              rd;
    logic              div_hit;
    logic              edge_now;
    logic              lead;
    logic              start_m;
    logic              start_s;
    logic              fault_m;
    logic              fault_s;
    logic [7:0]        stat_byte;

    // Address compare, used by every register decode
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] o);
        return a == o;
    endfunction : hit

    // Half serial clock period for a rate select
    function automatic logic [6:0] half_of(input logic [1:0] r);
        logic [6:0] h;
        h = `HALF_BD0;
        unique case (r)
            2'b00: h = `HALF_BD0;
            2'b01: h = `HALF_BD1;
            2'b10: h = `HALF_BD2;
            2'b11: h = `HALF_BD3;
        endcase
        return h;
    endfunction : half_of

    // Pin inputs into the bus clock domain
    pin_sync u_sync (
        .clk (REF_CLK),
        .rst (RST),
        .d   (PIN_I),
        .q   (pin_s)
    );

    // Control fields
    assign serial_port_enable  = core_reg.ctrl[`CA_SPE];
    assign mstr = core_reg.ctrl[`CA_MSTR];
    assign cpol = core_reg.ctrl[`CA_CPOL];
    assign clock_phase = core_reg.ctrl[`CA_CLOCK_PHASE];
    assign wom  = core_reg.ctrl[`CA_WOM];

    // Pin events seen through the synchroniser
    assign ss_low   = ~pin_s[`PIN_SS];
    assign ss_rise  = pin_s[`PIN_SS] & ~core_reg.ss_prev;
    assign ss_fall  = ~pin_s[`PIN_SS] & core_reg.ss_prev;
    assign sck_in   = pin_s[`PIN_SCK];
    assign sck_edge = sck_in ^ core_reg.sck_prev;
    assign in_bit   = mstr ? pin_s[`PIN_MISO] : pin_s[`PIN_MOSI];

    // Bus qualifiers; accesses in wait mode are refused
    assign protect = BREAK_ACTIVE & ~BREAK_CLEAR_EN;
    assign access  = PSEL & PENABLE & ~WAIT_MODE;
    assign wr      = access & PWRITE;
    assign rd      = access & ~PWRITE;

    // Serial clock edge timing for master and slave
    assign div_hit  = core_reg.div == half_of(core_reg.rate);
    assign edge_now = (core_reg.st == ST_SHIFT)
                    & (mstr ? div_hit : (ss_low & sck_edge));
    assign lead     = mstr ? ~core_reg.edges[0] : (sck_in != cpol);

    // Transfer start: master on queued data, slave on select or clock
    assign start_m = serial_port_enable & mstr & (core_reg.st == ST_IDLE)
                   & ~core_reg.txe;
    assign start_s = serial_port_enable & ~mstr & ss_low
                   & (clock_phase ? ((core_reg.st == ST_IDLE) & sck_edge
                              & (sck_in != cpol))
                           : ss_fall);

    // Mode faults
    assign fault_m = serial_port_enable & mstr & core_reg.mode_fault_enable & ss_low;
    assign fault_s = serial_port_enable & ~mstr & core_reg.mode_fault_enable & ss_rise
                   & (core_reg.st == ST_SHIFT);

    // Status byte as read by software
    assign stat_byte = {core_reg.rxf, core_reg.error_irq_enable, core_reg.ovr,
                        core_reg.mode_fault_flag, core_reg.txe, core_reg.mode_fault_enable,
                        core_reg.rate};

    // Next state of the core
    always_comb
    begin
        core_next = core_reg;

        // Read data captured in the setup phase
        if (PSEL & ~PENABLE)
        begin
            if (hit(PADDR, `OFS_CTRL))
                core_next.prdata = {24'h0, core_reg.ctrl};
            else if (hit(PADDR, `OFS_STAT))
                core_next.prdata = {24'h0, stat_byte};
            else if (hit(PADDR, `OFS_DATA))
                core_next.prdata = {24'h0, core_reg.rxd};
            else if (hit(PADDR, `OFS_PINS))
                core_next.prdata = {28'h0, pin_s};
            else
                core_next.prdata = 32'h0;
        end

        // First clearing step: status read arms flags that were seen set
        if (rd & hit(PADDR, `OFS_STAT) & ~protect)
        begin
            core_next.rxf_arm  = core_reg.prdata[`SC_RXF];
            core_next.ovr_arm  = core_reg.prdata[`SC_OVR];
            core_next.mode_fault_flag_arm = core_reg.prdata[`SC_MODE_FAULT_FLAG];
        end

        // Second step for receive full and overrun: data read
        if (rd & hit(PADDR, `OFS_DATA) & ~protect)
        begin
            if (core_reg.rxf_arm)
                core_next.rxf = 1'b0;
            if (core_reg.ovr_arm)
                core_next.ovr = 1'b0;
            core_next.rxf_arm = 1'b0;
            core_next.ovr_arm = 1'b0;
        end

        // Control write; also second step of mode fault clearing
        if (wr & hit(PADDR, `OFS_CTRL))
        begin
            core_next.ctrl = PWDATA[7:0] & `CA_MASK;
            if (~protect)
            begin
                if (core_reg.mode_fault_flag_arm & ~fault_m & ~fault_s)
                    core_next.mode_fault_flag = 1'b0;
                core_next.mode_fault_flag_arm = 1'b0;
            end
        end

        // Status control bits
        if (wr & hit(PADDR, `OFS_STAT))
        begin
            core_next.error_irq_enable  = PWDATA[`SC_ERROR_IRQ_ENABLE];
            core_next.mode_fault_enable = PWDATA[`SC_MODE_FAULT_ENABLE];
            core_next.rate   = PWDATA[`SC_RATE_HI:`SC_RATE_LO];
        end

        // Data write queues a byte unless flags are protected
        if (wr & hit(PADDR, `OFS_DATA) & ~protect)
        begin
            core_next.txd = PWDATA[7:0];
            core_next.txe = 1'b0;
        end

        // Transfer engine, frozen in stop mode
        if (~STOP_MODE)
        begin
            core_next.ss_prev  = pin_s[`PIN_SS];
            core_next.sck_prev = sck_in;

            // Load shift register from the queued byte
            if (start_m | start_s)
            begin
                if (~core_reg.txe)
                begin
                    core_next.sh  = core_reg.txd;
                    core_next.txe = 1'b1;
                end
                core_next.dout  = core_next.sh[7];
                core_next.edges = 4'h0;
                core_next.div   = 7'h00;
                core_next.sck   = cpol;
                core_next.st    = ST_SHIFT;
            end

            // One serial clock edge; sixteen edges make a byte
            if (edge_now | (start_s & clock_phase))
            begin
                if (mstr)
                begin
                    core_next.sck = ~core_reg.sck;
                    core_next.div = 7'h00;
                end
                if (~clock_phase & lead)
                    core_next.cap = in_bit;
                else if (~clock_phase)
                begin
                    core_next.sh   = {core_next.sh[6:0], core_reg.cap};
                    core_next.dout = core_next.sh[7];
                end
                else if (lead)
                    core_next.dout = core_next.sh[7];
                else
                    core_next.sh = {core_next.sh[6:0], in_bit};
                if (core_next.edges == `EDGES_LAST)
                    core_next.st = ST_DONE;
                core_next.edges = core_next.edges + 4'h1;
            end
            else if ((core_reg.st == ST_SHIFT) & mstr)
                core_next.div = core_reg.div + 7'h01;

            // Byte complete: receive register or overrun
            if (core_reg.st == ST_DONE)
            begin
                core_next.st = ST_IDLE;
                if (core_reg.rxf)
                    core_next.ovr = 1'b1;
                else
                begin
                    core_next.rxd = core_reg.sh;
                    core_next.rxf = 1'b1;
                end
            end
        end

        // Mode faults set the flag; a master fault disables the port
        if (fault_m)
        begin
            core_next.mode_fault_flag          = 1'b1;
            core_next.ctrl[`CA_SPE] = 1'b0;
        end
        if (fault_s)
            core_next.mode_fault_flag = 1'b1;

        // Partial reset while disabled; control bits and flags other than txe kept, txe set
        if (~serial_port_enable | fault_m)
        begin
            core_next.txe   = 1'b1;
            core_next.st    = ST_IDLE;
            core_next.sh    = 8'h00;
            core_next.edges = 4'h0;
            core_next.div   = 7'h00;
            core_next.sck   = cpol;
            core_next.dout  = 1'b0;
        end
    end

    // State register; system reset loads the constant reset image CORE_RST
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            core_reg <= CORE_RST;
        else
            core_reg <= core_next;
    end

    // APB answer: zero wait states, error on unmapped or blocked access
    assign PRDATA  = core_reg.prdata;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE
                   & (WAIT_MODE | ~(hit(PADDR, `OFS_CTRL)
                      | hit(PADDR, `OFS_STAT) | hit(PADDR, `OFS_DATA)
                      | hit(PADDR, `OFS_PINS)));

    // Requests and wake
    assign TX_IRQ     = core_reg.txe & core_reg.ctrl[`CA_TXIE] & serial_port_enable;
    assign RX_ERR_IRQ = (core_reg.rxf & core_reg.ctrl[`CA_RXIE])
                      | ((core_reg.ovr | core_reg.mode_fault_flag) & core_reg.error_irq_enable);
    assign WAKE       = WAIT_MODE & (TX_IRQ | RX_ERR_IRQ);

    // Pin ownership while the port is enabled; the select pin only as slave or with mode_fault_enable set
    assign own[`PIN_MISO] = serial_port_enable;
    assign own[`PIN_MOSI] = serial_port_enable;
    assign own[`PIN_SCK]  = serial_port_enable;
    assign own[`PIN_SS]   = serial_port_enable & (~mstr | core_reg.mode_fault_enable);

    // Port drive: open drain pulls low only in wired-or mode
    assign spi_o[`PIN_MISO]  = core_reg.dout & ~wom;
    assign spi_oe[`PIN_MISO] = serial_port_enable & ~mstr & ss_low
                             & (~wom | ~core_reg.dout);
    assign spi_o[`PIN_MOSI]  = core_reg.dout & ~wom;
    assign spi_oe[`PIN_MOSI] = serial_port_enable & mstr
                             & (~wom | ~core_reg.dout);
    assign spi_o[`PIN_SCK]   = core_reg.sck & ~wom;
    assign spi_oe[`PIN_SCK]  = serial_port_enable & mstr
                             & (~wom | ~core_reg.sck);
    assign spi_o[`PIN_SS]    = 1'b0;
    assign spi_oe[`PIN_SS]   = 1'b0;

    // Per-pin mux between port and shared I/O port
    genvar i;
    generate
        for (i = 0; i < `NPINS; i = i + 1)
        begin : g_pin
            assign PIN_O[i]  = own[i] ? spi_o[i] : PORT_DOUT[i];
            assign PIN_OE[i] = own[i] ? spi_oe[i] : PORT_DDR[i];
        end
    endgenerate

    // Pin levels always readable by the port data register
    assign PORT_DIN = pin_s;

endmodule : spi_enable_reset_pin_control

// ---- rtl/spi_pkg.sv ----
// Types shared by the serial port modules
package spi_pkg;
`include "spi_cfg.svh"

    // Transfer engine states, Gray coded along the path
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE  = 2'b11
    } eng_state_t;

    // Input synchroniser state
    typedef struct packed {
        logic [`NPINS-1:0] s1;
        logic [`NPINS-1:0] s2;
        logic [`NPINS-1:0] s3;
        logic [`NPINS-1:0] stable;
    } sync_t;

    // Whole state of the serial port core
    typedef struct packed {
        logic [7:0]  ctrl;
        logic        error_irq_enable;
        logic        mode_fault_enable;
        logic [1:0]  rate;
        logic        rxf;
        logic        ovr;
        logic        mode_fault_flag;
        logic        txe;
        logic        rxf_arm;
        logic        ovr_arm;
        logic        mode_fault_flag_arm;
        logic [7:0]  txd;
        logic [7:0]  rxd;
        logic [7:0]  sh;
        logic        cap;
        logic        dout;
        logic [3:0]  edges;
        eng_state_t  st;
        logic [6:0]  div;
        logic        sck;
        logic        ss_prev;
        logic        sck_prev;
        logic [31:0] prdata;
    } core_t;

endpackage : spi_pkg

// ---- testbench/spi_far_model.sv ----
// Far-side serial slave for clock phase one, idle-low clock
`timescale 1ns/1ns
module spi_far_model
(
    // Wire side
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    output logic            miso,
    // Answer byte, taken byte and bit count
    input  wire logic [7:0] reply,
    output logic [7:0]      got,
    output logic [3:0]      nbits
);
    logic [7:0] sh;

    initial
    begin
        miso = 1'b1;
        got = 8'h00;
        nbits = 4'h0;
        sh = 8'h00;
    end
    // Select falling loads the answer and restarts the count
    always @(negedge sel_n)
    begin
        sh = reply;
        nbits = 4'h0;
    end
    // Released line shows the inverse of its last level
    always @(posedge sel_n)
        miso = ~miso;
    // Leading edge puts out the next bit, msb first
    always @(posedge sck)
        if (!sel_n)
        begin
            miso = sh[7];
            sh = {sh[6:0], 1'b0};
        end
    // Trailing edge takes the master's bit
    always @(negedge sck)
        if (!sel_n)
        begin
            got = {got[6:0], mosi};
            nbits = nbits + 4'h1;
        end
endmodule : spi_far_model

// ---- testbench/spi_port_checker.sv ----
// Assertions on bus refusals, pin ownership and request outputs
`timescale 1ns/1ns
`include "spi_cfg.svh"
module spi_port_checker
    import spi_pkg::*;
(
    // Clock, reset and bus
    input wire logic              REF_CLK,
    input wire logic              RST,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [7:0]        PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic              PSLVERR,
    // System state
    input wire logic              WAIT_MODE,
    input wire logic              STOP_MODE,
    // Port and pins
    input wire logic [`NPINS-1:0] PORT_DDR,
    input wire logic [`NPINS-1:0] PORT_DOUT,
    input wire logic [`NPINS-1:0] PORT_DIN,
    input wire logic [`NPINS-1:0] PIN_I,
    input wire logic [`NPINS-1:0] PIN_O,
    input wire logic [`NPINS-1:0] PIN_OE,
    // Requests
    input wire logic              TX_IRQ,
    input wire logic              RX_ERR_IRQ,
    input wire logic              WAKE
);
    // One domain: sample on the bus clock, hold off during reset
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    reset_pins_a: assert property ($past(RST) |->
        PIN_OE == PORT_DDR && PIN_O == PORT_DOUT && !TX_IRQ && !RX_ERR_IRQ)
        else $error("pins or requests not idle after reset");
    wait_refuse_a: assert property (PSEL && PENABLE && WAIT_MODE |-> PSLVERR)
        else $error("access in wait mode not refused");
    wake_req_a: assert property (WAIT_MODE && (TX_IRQ || RX_ERR_IRQ) |-> WAKE)
        else $error("enabled request did not wake");
    wake_only_a: assert property (WAKE |-> WAIT_MODE && (TX_IRQ || RX_ERR_IRQ))
        else $error("wake without cause");
    ss_undriven_a: assert property (PIN_OE[`PIN_SS] |->
        PORT_DDR[`PIN_SS] && PIN_O[`PIN_SS] == PORT_DOUT[`PIN_SS])
        else $error("select pin driven by the port");
    ss_visible_a: assert property ($stable(PIN_I[`PIN_SS]) [*6] |->
        PORT_DIN[`PIN_SS] == PIN_I[`PIN_SS])
        else $error("select level not readable");
    stop_freeze_a: assert property (STOP_MODE && $past(STOP_MODE) && !PSEL
        && $stable(PORT_DDR) && $stable(PORT_DOUT) && $stable(PIN_I[`PIN_SS])
        |-> $stable(PIN_O) && $stable(PIN_OE))
        else $error("pins moved in stop mode");
    disable_pins_a: assert property (PSEL && PENABLE && PWRITE && !WAIT_MODE
        && PADDR == `OFS_CTRL && !PWDATA[`CA_SPE]
        |=> !TX_IRQ && PIN_OE == PORT_DDR && PIN_O == PORT_DOUT)
        else $error("disabled port kept its pins");
endmodule : spi_port_checker

bind spi_enable_reset_pin_control spi_port_checker i_chk (
    .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR),
    .WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE), .PORT_DDR(PORT_DDR),
    .PORT_DOUT(PORT_DOUT), .PORT_DIN(PORT_DIN), .PIN_I(PIN_I),
    .PIN_O(PIN_O), .PIN_OE(PIN_OE), .TX_IRQ(TX_IRQ),
    .RX_ERR_IRQ(RX_ERR_IRQ), .WAKE(WAKE));

// ---- testbench/tb_top.sv ----
// Bench: register bus, transfers, partial reset, break, mode fault, pins
`timescale 1ns/1ns
`include "spi_cfg.svh"
module tb_top;
    logic              REF_CLK = 1'b0;
    logic              RST = 1'b1;
    logic              PSEL = 1'b0;
    logic              PENABLE = 1'b0;
    logic              PWRITE = 1'b0;
    logic [7:0]        PADDR = 8'h00;
    logic [31:0]       PWDATA = 32'h0;
    logic              WAIT_MODE = 1'b0;
    logic              STOP_MODE = 1'b0;
    logic              BREAK_ACTIVE = 1'b0;
    logic              BREAK_CLEAR_EN = 1'b0;
    logic [`NPINS-1:0] PORT_DDR = 4'h0;
    logic [`NPINS-1:0] PORT_DOUT = 4'h0;
    wire  [`NPINS-1:0] PIN_I;
    logic [31:0]       PRDATA;
    logic              PREADY, PSLVERR, TX_IRQ, RX_ERR_IRQ, WAKE;
    logic [`NPINS-1:0] PORT_DIN, PIN_O, PIN_OE;
    logic              ss_n = 1'b1;
    logic              sel_n = 1'b1;
    logic              sck_drv = 1'b0;
    logic              mosi_drv = 1'b0;
    logic              miso;
    logic [7:0]        reply = 8'h00;
    logic [7:0]        got;
    logic [3:0]        nbits;
    logic [31:0]       seed = 32'h43DE;
    logic [31:0]       rq[$];
    int                err_total = 0;
    int                n_tests = 0;
    int                cycles = 0;

    always #10 REF_CLK = ~REF_CLK;
    // Driven pins show the port's level, others the far side's
    assign PIN_I = (PIN_OE & PIN_O)
                 | (~PIN_OE & {ss_n, sck_drv, mosi_drv, miso});

    spi_enable_reset_pin_control i_dut (
        .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .WAIT_MODE(WAIT_MODE),
        .STOP_MODE(STOP_MODE), .BREAK_ACTIVE(BREAK_ACTIVE),
        .BREAK_CLEAR_EN(BREAK_CLEAR_EN), .PORT_DDR(PORT_DDR),
        .PORT_DOUT(PORT_DOUT), .PORT_DIN(PORT_DIN), .PIN_I(PIN_I),
        .PIN_O(PIN_O), .PIN_OE(PIN_OE), .TX_IRQ(TX_IRQ),
        .RX_ERR_IRQ(RX_ERR_IRQ), .WAKE(WAKE));
    spi_far_model i_far (.sck(PIN_I[`PIN_SCK]), .mosi(PIN_I[`PIN_MOSI]),
        .sel_n(sel_n), .miso(miso), .reply(reply), .got(got), .nbits(nbits));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected at %0t: %h vs %h", $time, g, e);
        end
    endtask : cmp

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    // One bus transfer, held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do
            @(posedge REF_CLK);
        while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // One byte each way, with a stop spell in mid-transfer
    task automatic xfer(output logic [7:0] ans);
        logic [31:0] r;
        r = rnd();
        reply <= r[15:8];
        sel_n <= 1'b1;
        @(posedge REF_CLK);
        sel_n <= 1'b0;
        apb(1'b1, `OFS_DATA, {24'h0, r[7:0]});
        STOP_MODE <= 1'b1;
        repeat (20) @(posedge REF_CLK);
        STOP_MODE <= 1'b0;
        while (nbits != 4'h8)
            @(posedge REF_CLK);
        repeat (3) @(posedge REF_CLK);
        cmp({24'h0, got}, {24'h0, r[7:0]});
        ans = r[15:8];
    endtask : xfer

    task automatic reset_dut();
        RST <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        rd(`OFS_CTRL, 32'h28);
        rd(`OFS_STAT, 32'h08);
        rd(`OFS_DATA, 32'h0);
        rd(8'h10, 32'h0);
        $display("test reset done");
    endtask : reset_dut

    // Read data against the oldest note
    always @(posedge REF_CLK)
        if (PSEL && PENABLE && PREADY && !PWRITE)
            cmp(PRDATA, rq.pop_front());

    // Cycle ceiling against a hang
    always @(posedge REF_CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    initial
    begin
        logic [7:0]  ans;
        logic [31:0] r;
        reset_dut();
        WAIT_MODE <= 1'b1;
        apb(1'b1, `OFS_CTRL, 32'hFF);
        WAIT_MODE <= 1'b0;
        rd(`OFS_CTRL, 32'h28);
        apb(1'b1, `OFS_STAT, 32'h01);
        apb(1'b1, `OFS_CTRL, 32'hAB);
        @(negedge REF_CLK);
        cmp({31'h0, TX_IRQ}, 32'h1);
        @(posedge REF_CLK);
        for (int i = 0; i < 4; i++)
        begin
            xfer(ans);
            rd(`OFS_STAT, 32'h89);
            WAIT_MODE <= 1'b1;
            @(negedge REF_CLK);
            cmp({30'h0, RX_ERR_IRQ, WAKE}, 32'h3);
            @(posedge REF_CLK);
            WAIT_MODE <= 1'b0;
            if (i < 3)
            begin
                BREAK_ACTIVE <= i[0];
                BREAK_CLEAR_EN <= i[0];
                rd(`OFS_DATA, {24'h0, ans});
                rd(`OFS_STAT, 32'h09);
            end
        end
        $display("test transfers done");
        apb(1'b1, `OFS_STAT, 32'h47);
        apb(1'b1, `OFS_CTRL, 32'hA9);
        r = rnd();
        PORT_DOUT <= r[3:0];
        PORT_DDR <= {1'b0, r[6:4]};
        @(negedge REF_CLK);
        cmp({22'h0, PIN_OE, PIN_O, TX_IRQ, RX_ERR_IRQ},
            {22'h0, PORT_DDR, PORT_DOUT, 2'b01});
        @(posedge REF_CLK);
        rd(`OFS_CTRL, 32'hA9);
        rd(`OFS_STAT, 32'hCF);
        PORT_DDR <= 4'h0;
        $display("test partial reset done");
        apb(1'b1, `OFS_CTRL, 32'hAB);
        rd(`OFS_STAT, 32'hCF);
        BREAK_ACTIVE <= 1'b1;
        rd(`OFS_DATA, {24'h0, ans});
        sel_n <= 1'b1;
        @(posedge REF_CLK);
        sel_n <= 1'b0;
        apb(1'b1, `OFS_DATA, 32'h5A);
        repeat (300) @(posedge REF_CLK);
        cmp({28'h0, nbits}, 32'h0);
        rd(`OFS_STAT, 32'hCF);
        BREAK_ACTIVE <= 1'b0;
        rd(`OFS_DATA, {24'h0, ans});
        rd(`OFS_STAT, 32'h4F);
        $display("test break done");
        ss_n <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        rd(`OFS_STAT, 32'h5F);
        rd(`OFS_CTRL, 32'hA9);
        @(negedge REF_CLK);
        cmp({31'h0, RX_ERR_IRQ}, 32'h1);
        @(posedge REF_CLK);
        ss_n <= 1'b1;
        $display("test mode fault done");
        apb(1'b1, `OFS_CTRL, 32'h0A);
        for (int k = 0; k < 2; k++)
        begin
            ss_n <= ~k[0];
            repeat (8) @(posedge REF_CLK);
            @(negedge REF_CLK);
            cmp({31'h0, PIN_OE[`PIN_MISO]}, {31'h0, k[0]});
            @(posedge REF_CLK);
        end
        // Slave byte: two clock edges while deselected, then sixteen
        r = rnd();
        for (int b = 0; b < 18; b++)
        begin
            ss_n <= (b < 2);
            repeat (4) @(posedge REF_CLK);
            sck_drv <= ~sck_drv;
            mosi_drv <= r[(17 - b) >> 1];
        end
        repeat (8) @(posedge REF_CLK);
        ss_n <= 1'b1;
        rd(`OFS_DATA, {24'h0, r[7:0]});
        $display("test slave pins done");
        reset_dut();
        conclude();
    end
endmodule : tb_top
